// [verilog/i2c_pwr_pkg.sv]
// shared constants for the light-sensor serial target and its controller
// assumes a 10 MHz pclk on both ends
package i2c_pwr_pkg;
  // clocks and times
  localparam int PCLK_KHZ     = 10000;
  localparam int OSC_KHZ      = 720;
  localparam int INIT_TIME_US = 500;
  localparam int INIT_CYCLES  = INIT_TIME_US * PCLK_KHZ / 1000;
  localparam int SCL_MAX_KHZ  = 400;
  localparam int SCL_QUARTER  = (PCLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
  // target register map
  localparam logic [6:0] DEV_ADDR_DEF = 7'h29;
  localparam logic [7:0] REG_ENABLE   = 8'h80;
  localparam logic [7:0] REG_HOLD     = 8'h9f;
  localparam logic [7:0] REG_CFG0     = 8'ha1;
  localparam logic [7:0] REG_CONTROL  = 8'hb1;
  localparam logic [7:0] PAIR_LO0     = 8'h95;
  localparam logic [7:0] PAIR_LO1     = 8'h97;
  localparam logic [7:0] PAIR_LO2     = 8'h99;
  localparam int POWER_ON_BIT = 0;
  localparam int ALS_BIT   = 1;
  localparam int FD_BIT    = 6;
  localparam int SLEEP_IRQ_BIT = 2;
  localparam int HOLD_BIT  = 0;
  localparam int CLR_BIT   = 0;
  // controller apb map
  localparam logic [7:0] H_CMD  = 8'h00;
  localparam logic [7:0] H_DATA = 8'h04;
  localparam logic [7:0] H_STAT = 8'h08;
  localparam int CMD_RD_BIT   = 8;
  localparam int CMD_SKIP_BIT = 9;
  localparam int CMD_TWO_BIT  = 10;
  typedef enum logic [1:0] {PS_INIT, PS_SLEEP, PS_IDLE, PS_ACTIVE} pstate_t;
  // low byte of a latched 16-bit field
  function automatic logic is_pair_lo(input logic [7:0] a);
    return a == PAIR_LO0 || a == PAIR_LO1 || a == PAIR_LO2;
  endfunction
endpackage

// [verilog/i2c_link_if.sv]
// open-drain two-wire link between controller and target
// assumes pull-ups: a line is high unless some end enables its driver
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_o_ctl;
  logic scl_oe_ctl;
  logic sda_o_ctl;
  logic sda_oe_ctl;
  logic sda_o_tgt;
  logic sda_oe_tgt;
  logic scl;
  logic sda;
  // sda is the wired-and of both ends; only the controller drives scl
  assign scl = scl_oe_ctl ? scl_o_ctl : 1'b1;
  assign sda = (sda_oe_ctl ? sda_o_ctl : 1'b1) & (sda_oe_tgt ? sda_o_tgt : 1'b1);
  modport target (input scl, input sda, output sda_o_tgt, output sda_oe_tgt);
  modport controller (input scl, input sda, output scl_o_ctl, output scl_oe_ctl,
                      output sda_o_ctl, output sda_oe_ctl);
endinterface

// [verilog/i2c_target_pwr.sv]
// serial register target with power-state sequencing
// assumes scl/sda arrive asynchronously; irq_event is a pclk pulse
// What this block does
// - nack everything during 500us init
// - host waits out init, ignores outputs
// - after init go to sleep, oscillator off
// - bus serviced while asleep, then dormant
// - power_on_bit moves device to idle
// - light_sense_enable leaves idle; all off returns
// - light and flicker functions run concurrently
// - sleep_after_interrupt sleeps on interrupt, registers kept
// - sleep holds until host clears sleep_hold_flag
// - 7-bit address, up to 400 kHz
// - 8-bit pointer increments per data byte
// - pointer survives stop; bare read continues
// - low-byte read latches whole 16-bit field
// - host reads/writes low byte then high
// - host should prefer burst transfers
// - write framing; target acks ninth clock
// - host may stop after target nack
// - read framing with repeated start
// - host acks all but last byte
// - internal oscillator nominally 720 kHz
// - idle: power on, all functions off
// - power_on_bit clear means sleep
//
// Added by the designer: the address map; the APB register port is in the controller.
`timescale 1ns/1ps
module i2c_target_pwr
  import i2c_pwr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = i2c_pwr_pkg::DEV_ADDR_DEF,
  parameter int         INIT_CNT = i2c_pwr_pkg::INIT_CYCLES
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // serial link
  i2c_link_if.target                bus,
  // user side
  input  wire logic                 irq_event,
  output      i2c_pwr_pkg::pstate_t power_state,
  output      logic                 osc_run,
  output      logic                 osc_tick,
  output      logic                 als_run,
  output      logic                 flicker_run,
  output      logic                 i2c_awake
);
  import i2c_pwr_pkg::*;

  typedef enum logic [2:0] {
    B_IDLE, B_IGNORE, B_ADDR, B_REG, B_WDATA, B_ACK, B_RDATA, B_RACK
  } bus_t;

  typedef struct packed {
    logic [1:0]        scl_s;
    logic [1:0]        sda_s;
    logic              scl_p;
    logic              sda_p;
    bus_t              bst;
    bus_t              after;
    logic [7:0]        sh;
    logic [3:0]        bcnt;
    logic              nack_in;
    logic              sda_oe;
    logic [7:0]        ptr;
    logic [7:0]        latch;
    logic [7:0]        stage;
    logic [15:0]       init_cnt;
    logic              init_done;
    logic              hold;
    pstate_t           ps;
    logic              osc_run;
    logic              osc_tick;
    logic              als_run;
    logic              fd_run;
    logic              awake;
    logic [13:0]       acc;
    logic [255:0][7:0] mem;
  } st_t;

  st_t q;
  st_t n;
  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       load;
  logic       clr;
  logic [7:0] byte_out;
  logic [7:0] prev;
  logic [14:0] sum;

  assign bus.sda_o_tgt = 1'b0;
  assign bus.sda_oe_tgt = q.sda_oe;

  // next-state logic for link, register space and power states
  always_comb begin
    n = q;
    n.osc_tick = 1'b0;
    load = 1'b0;
    clr = 1'b0;
    byte_out = 8'h00;
    prev = 8'(q.ptr - 8'h01);
    sum = 15'h0000;
    // two flops before anything looks at the pins
    n.scl_s = {q.scl_s[0], bus.scl};
    n.sda_s = {q.sda_s[0], bus.sda};
    n.scl_p = q.scl_s[1];
    n.sda_p = q.sda_s[1];
    scl = q.scl_s[1];
    sda = q.sda_s[1];
    rise = scl & ~q.scl_p;
    fall = ~scl & q.scl_p;
    start = scl & q.scl_p & q.sda_p & ~sda;
    stop = scl & q.scl_p & ~q.sda_p & sda;

    // init window counter
    if (!q.init_done) begin
      if (q.init_cnt == 16'(INIT_CNT - 1)) begin
        n.init_done = 1'b1;
      end else begin
        n.init_cnt = q.init_cnt + 16'h0001;
      end
    end

    // byte engine; pclk oversampling covers 400 kHz with margin
    if (start) begin
      n.bst = B_ADDR;
      n.bcnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.bst = B_IDLE; // pointer kept across stop
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.bst)
        B_IDLE, B_IGNORE: begin
        end
        B_ADDR, B_REG, B_WDATA: begin
          if (rise) begin
            n.sh = {q.sh[6:0], sda};
            n.bcnt = q.bcnt + 4'h1;
          end else if (fall && q.bcnt == 4'h8) begin
            n.bcnt = 4'h0;
            n.bst = B_ACK;
            n.sda_oe = 1'b1; // ack on the ninth clock
            if (q.bst == B_ADDR) begin
              // silent during init, so the address goes unanswered
              if (q.sh[7:1] == DEV_ADDR && q.init_done) begin
                n.after = q.sh[0] ? B_RDATA : B_REG;
              end else begin
                n.bst = B_IGNORE;
                n.sda_oe = 1'b0;
              end
            end else if (q.bst == B_REG) begin
              n.ptr = q.sh;
              n.after = B_WDATA;
            end else begin
              n.after = B_WDATA;
              n.ptr = q.ptr + 8'h01;
              if (is_pair_lo(q.ptr)) begin
                n.stage = q.sh; // held until the high byte
              end else if (is_pair_lo(prev)) begin
                n.mem[prev] = q.stage;
                n.mem[q.ptr] = q.sh;
              end else if (q.ptr == REG_CONTROL) begin
                clr = q.sh[CLR_BIT];
              end else if (q.ptr != REG_HOLD) begin
                n.mem[q.ptr] = q.sh;
              end
            end
          end
        end
        B_ACK: begin
          if (fall) begin
            n.sda_oe = 1'b0;
            n.bst = q.after;
            load = q.after == B_RDATA;
          end
        end
        B_RDATA: begin
          if (rise) begin
            n.bcnt = q.bcnt + 4'h1;
          end else if (fall) begin
            if (q.bcnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.bst = B_RACK;
              n.ptr = q.ptr + 8'h01;
            end else begin
              n.sh = {q.sh[6:0], 1'b0};
              n.sda_oe = ~q.sh[6];
            end
          end
        end
        B_RACK: begin
          if (rise) begin
            n.nack_in = sda;
          end else if (fall) begin
            if (q.nack_in) begin
              n.bst = B_IGNORE;
            end else begin
              n.bst = B_RDATA;
              load = 1'b1;
            end
          end
        end
        default: n.bst = B_IDLE;
      endcase
    end

    // fetch the next byte to send and drive its msb
    if (load) begin
      if (q.ptr == REG_HOLD) begin
        byte_out = 8'h00;
        byte_out[HOLD_BIT] = q.hold;
      end else if (is_pair_lo(prev)) begin
        byte_out = q.latch;
      end else begin
        byte_out = q.mem[q.ptr];
      end
      if (is_pair_lo(q.ptr)) begin
        n.latch = q.mem[8'(q.ptr + 8'h01)];
      end
      n.sh = byte_out;
      n.bcnt = 4'h0;
      n.sda_oe = ~byte_out[7];
    end

    // sleep hold: a new interrupt beats a clear in the same cycle
    n.hold = (irq_event && q.mem[REG_CFG0][SLEEP_IRQ_BIT] && q.ps == PS_ACTIVE)
             || (q.hold && !clr);

    // power state; registers stay untouched when the hold forces sleep
    if (!q.init_done) begin
      n.ps = PS_INIT;
    end else if (q.hold || !q.mem[REG_ENABLE][POWER_ON_BIT]) begin
      n.ps = PS_SLEEP;
    end else if (q.mem[REG_ENABLE][ALS_BIT] || q.mem[REG_ENABLE][FD_BIT]) begin
      n.ps = PS_ACTIVE;
    end else begin
      n.ps = PS_IDLE;
    end
    // bus activity alone never enables a function
    n.osc_run = q.ps == PS_IDLE || q.ps == PS_ACTIVE;
    n.als_run = q.ps == PS_ACTIVE && q.mem[REG_ENABLE][ALS_BIT];
    n.fd_run = q.ps == PS_ACTIVE && q.mem[REG_ENABLE][FD_BIT];
    n.awake = q.bst != B_IDLE && q.bst != B_IGNORE;

    // oscillator tick by fractional accumulation
    if (q.osc_run) begin
      sum = {1'b0, q.acc} + 15'(OSC_KHZ);
      if (sum >= 15'(PCLK_KHZ)) begin
        n.acc = 14'(sum - 15'(PCLK_KHZ));
        n.osc_tick = 1'b1;
      end else begin
        n.acc = sum[13:0];
      end
    end else begin
      n.acc = 14'h0000;
    end
  end

  // state register; everything resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign power_state = q.ps;
  assign osc_run = q.osc_run;
  assign osc_tick = q.osc_tick;
  assign als_run = q.als_run;
  assign flicker_run = q.fd_run;
  assign i2c_awake = q.awake;
endmodule

// [verilog/i2c_ctl_apb.sv]
// serial link controller ordered over apb
// assumes the target never stretches the clock
`timescale 1ns/1ps
module i2c_ctl_apb
  import i2c_pwr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = i2c_pwr_pkg::DEV_ADDR_DEF,
  parameter int         QUARTER  = i2c_pwr_pkg::SCL_QUARTER
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // serial link
  i2c_link_if.controller   bus
);
  import i2c_pwr_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} ph_t;
  typedef enum logic [2:0] {SQ_ADDRW, SQ_REG, SQ_ADDRR, SQ_D0, SQ_D1} sq_t;

  typedef struct packed {
    logic [1:0]  sda_s;
    ph_t         ph;
    sq_t         sq;
    logic [1:0]  qtr;
    logic [3:0]  div;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        scl_low;
    logic        sda_oe;
    logic        busy;
    logic        nack;
    logic        done;
    logic [7:0]  reg_a;
    logic        rd;
    logic        skip;
    logic        two;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } st_t;

  st_t q;
  st_t n;
  logic reading;
  logic last;

  assign bus.scl_o_ctl = 1'b0;
  assign bus.sda_o_ctl = 1'b0;
  assign bus.scl_oe_ctl = q.scl_low;
  assign bus.sda_oe_ctl = q.sda_oe;

  // next-state logic: apb slave plus bit sequencer
  always_comb begin
    n = q;
    n.sda_s = {q.sda_s[0], bus.sda};
    reading = q.rd && (q.sq == SQ_D0 || q.sq == SQ_D1);
    last = q.sq == SQ_D1 || (q.sq == SQ_D0 && !q.two);

    // one wait state: pready rises in the second access cycle
    n.pready = psel && penable && !q.pready;
    if (psel && penable && !q.pready) begin
      n.pslverr = paddr != H_CMD && paddr != H_DATA && paddr != H_STAT;
      n.prdata = 32'h0000_0000;
      if (paddr == H_DATA) begin
        n.prdata[15:0] = q.rdat;
      end else if (paddr == H_STAT) begin
        n.prdata[2:0] = {q.done, q.nack, q.busy};
      end
    end
    if (psel && penable && q.pready && pwrite) begin
      if (paddr == H_DATA) begin
        n.wdat = pwdata[15:0];
      end else if (paddr == H_CMD && !q.busy) begin
        // a command while busy is dropped
        n.reg_a = pwdata[7:0];
        n.rd = pwdata[CMD_RD_BIT];
        n.skip = pwdata[CMD_SKIP_BIT];
        n.two = pwdata[CMD_TWO_BIT];
        n.busy = 1'b1;
        n.nack = 1'b0;
        n.done = 1'b0;
        n.ph = H_START;
        n.qtr = 2'h0;
        n.div = 4'h0;
        n.sq = (pwdata[CMD_RD_BIT] && pwdata[CMD_SKIP_BIT]) ? SQ_ADDRR : SQ_ADDRW;
      end
    end

    // quarter-bit timer keeps scl at or under 400 kHz
    if (q.ph != H_IDLE) begin
      if (q.div == 4'(QUARTER - 1)) begin
        n.div = 4'h0;
        n.qtr = q.qtr + 2'h1;
        unique case (q.ph)
          H_START: begin
            unique case (q.qtr)
              2'h0: n.sda_oe = 1'b0;
              2'h1: n.scl_low = 1'b0;
              2'h2: n.sda_oe = 1'b1; // start or repeated start
              default: begin
                n.scl_low = 1'b1;
                n.ph = H_BITS;
                n.bitn = 4'h0;
                unique case (q.sq)
                  SQ_ADDRW: n.sh = {DEV_ADDR, 1'b0};
                  default: n.sh = {DEV_ADDR, 1'b1};
                endcase
              end
            endcase
          end
          H_BITS: begin
            unique case (q.qtr)
              2'h0: begin
                if (q.bitn == 4'h8) begin
                  n.sda_oe = reading && !last;
                end else begin
                  n.sda_oe = !reading && !q.sh[7];
                end
              end
              2'h1: n.scl_low = 1'b0;
              2'h2: begin
                if (q.bitn == 4'h8) begin
                  n.nack = !reading && q.sda_s[1];
                end else begin
                  n.sh = {q.sh[6:0], q.sda_s[1]};
                end
              end
              default: begin
                n.scl_low = 1'b1;
                n.bitn = q.bitn + 4'h1;
                if (q.bitn == 4'h8) begin
                  n.bitn = 4'h0;
                  if (reading && q.sq == SQ_D0) begin
                    n.rdat[7:0] = q.sh;
                  end else if (reading) begin
                    n.rdat[15:8] = q.sh;
                  end
                  if (q.nack || last) begin
                    n.ph = H_STOP;
                  end else begin
                    unique case (q.sq)
                      SQ_ADDRW: begin
                        n.sq = SQ_REG;
                        n.sh = q.reg_a;
                      end
                      SQ_REG: begin
                        if (q.rd) begin
                          n.sq = SQ_ADDRR;
                          n.ph = H_START;
                        end else begin
                          n.sq = SQ_D0;
                          n.sh = q.wdat[7:0];
                        end
                      end
                      SQ_ADDRR: begin
                        n.sq = SQ_D0;
                        n.sh = 8'hff;
                      end
                      default: begin
                        n.sq = SQ_D1; // low byte then high
                        n.sh = q.rd ? 8'hff : q.wdat[15:8];
                      end
                    endcase
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (q.qtr)
              2'h0: n.sda_oe = 1'b1;
              2'h1: n.scl_low = 1'b0;
              2'h2: n.sda_oe = 1'b0;
              default: begin
                n.ph = H_IDLE;
                n.busy = 1'b0;
                n.done = 1'b1;
              end
            endcase
          end
          default: n.ph = H_IDLE;
        endcase
      end else begin
        n.div = q.div + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
endmodule

// [verification/i2c_pwr_assertions.sv]
// concurrent checks on the two-wire link and the target's power outputs
// assumes one pclk domain; instantiated beside the link interface in tb
`timescale 1ns/1ps
module i2c_pwr_assertions
  import i2c_pwr_pkg::*;
(
  // clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // link signals
  input wire logic                 scl,
  input wire logic                 sda,
  input wire logic                 sda_oe_tgt,
  // target user side
  input wire i2c_pwr_pkg::pstate_t power_state,
  input wire logic                 osc_run,
  input wire logic                 osc_tick,
  input wire logic                 als_run,
  input wire logic                 flicker_run,
  input wire logic                 i2c_awake
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // at 720 kHz from 10 MHz no two ticks can be closer than 13 cycles
  sequence tick_quiet;
    !osc_tick [*8];
  endsequence
  sequence left_init;
    $past(power_state) == PS_INIT && power_state != PS_INIT;
  endsequence

  chk_init_nack: assert property (power_state == PS_INIT |-> !sda_oe_tgt)
    else $error("target drove sda during init");
  chk_init_exit: assert property (left_init |-> power_state == PS_SLEEP)
    else $error("init did not end in sleep");
  // state and run flags are separate registers, so allow one settling cycle
  chk_sleep_quiet: assert property (power_state == PS_SLEEP && $past(power_state) == PS_SLEEP
    |-> !osc_run && !als_run && !flicker_run)
    else $error("oscillator or function running in sleep");
  chk_idle_osc: assert property (power_state == PS_IDLE && $past(power_state) == PS_IDLE
    |-> osc_run && !als_run && !flicker_run)
    else $error("idle state with wrong run flags");
  chk_als_active: assert property (als_run
    |-> power_state == PS_ACTIVE || $past(power_state) == PS_ACTIVE)
    else $error("light function outside active");
  chk_flick_active: assert property (flicker_run
    |-> power_state == PS_ACTIVE || $past(power_state) == PS_ACTIVE)
    else $error("flicker function outside active");
  chk_tick_gated: assert property (osc_tick |-> osc_run || $past(osc_run))
    else $error("oscillator tick while stopped");
  chk_tick_gap: assert property (osc_tick |=> tick_quiet)
    else $error("oscillator ticks too close");
  chk_sda_stands: assert property (scl && $past(scl) |-> $stable(sda_oe_tgt))
    else $error("target moved sda while scl high");
  // start is seen through two sync flops plus the edge detector, so allow a few cycles
  chk_awake_start: assert property (scl && $fell(sda) |-> ##[1:6] i2c_awake)
    else $error("target stayed dormant after start");
  // the accumulator gives gaps of 13 or 14 cycles while the oscillator runs
  chk_tick_due: assert property (osc_tick |-> ##[1:14] (osc_tick || !osc_run))
    else $error("oscillator tick overdue");
  cov_both_run: cover property (als_run && flicker_run);
endmodule

// [verification/tb.sv]
// self-checking bench: apb-ordered controller facing the target over the link
// assumes a 10 MHz pclk and a shortened init count
`timescale 1ns/1ps
module tb;
  import i2c_pwr_pkg::*;
  localparam int INIT_SIM = 2000;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 irq_event;
  pstate_t              power_state;
  logic                 osc_run;
  logic                 osc_tick;
  logic                 als_run;
  logic                 flicker_run;
  logic                 i2c_awake;
  int                   fail_count;
  int                   check_count;
  logic [7:0]           mem [256];
  logic [7:0]           ptr;
  logic [31:0]          r1;
  logic                 e1;

  i2c_link_if link ();
  i2c_target_pwr #(.INIT_CNT(INIT_SIM)) i2c_target_pwr_i (
    .pclk(pclk), .presetn(presetn), .bus(link.target), .irq_event(irq_event),
    .power_state(power_state), .osc_run(osc_run), .osc_tick(osc_tick),
    .als_run(als_run), .flicker_run(flicker_run), .i2c_awake(i2c_awake));
  i2c_ctl_apb i2c_ctl_apb_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(link.controller));
  i2c_pwr_assertions chk_i (
    .pclk(pclk), .presetn(presetn), .scl(link.scl), .sda(link.sda),
    .sda_oe_tgt(link.sda_oe_tgt), .power_state(power_state), .osc_run(osc_run),
    .osc_tick(osc_tick), .als_run(als_run), .flicker_run(flicker_run),
    .i2c_awake(i2c_awake));

  // free-running 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  // one apb transfer; entered just after a rising edge, holds until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed wait count; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one link transaction ordered through the controller, waited out by polling
  task automatic op(input logic rd, input logic sk, input logic two, input logic [7:0] ra,
                    input logic [15:0] wd, output logic [15:0] got, output logic nk);
    logic [31:0] r;
    logic        e;
    int          n;
    if (!rd) apb(1'b1, H_DATA, {16'h0000, wd}, r, e);
    apb(1'b1, H_CMD, {21'h000000, two, sk, rd, ra}, r, e);
    n = 0;
    do begin
      apb(1'b0, H_STAT, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 500);
    if (n >= 500) chk(32'h1, 32'h0, "controller stuck busy");
    nk = r[1];
    apb(1'b0, H_DATA, 32'h0, r, e);
    got = r[15:0];
  endtask

  // write through the link and update the reference model
  task automatic wr(input logic [7:0] ra, input logic two, input logic [15:0] wd,
                    input logic xnk);
    logic [15:0] g;
    logic        nk;
    op(1'b0, 1'b0, two, ra, wd, g, nk);
    chk({31'h0, nk}, {31'h0, xnk}, "write acknowledge");
    if (!xnk) begin
      if (ra == REG_CONTROL && wd[CLR_BIT]) mem[REG_HOLD] = 8'h00;
      if (ra != REG_CONTROL && ra != REG_HOLD) mem[ra] = wd[7:0];
      if (two) mem[ra + 8'h01] = wd[15:8];
      ptr = ra + 8'h01 + {7'h00, two};
    end
  endtask

  // read through the link, expectation from the model and its pointer
  task automatic rd(input logic [7:0] ra, input logic sk, input logic two);
    logic [15:0] g;
    logic        nk;
    logic [7:0]  b;
    b = sk ? ptr : ra;
    op(1'b1, sk, two, ra, 16'h0, g, nk);
    chk({31'h0, nk}, 32'h0, "read acknowledge");
    if (!two) g[15:8] = 8'h00;
    chk({16'h0, g}, {16'h0, (two ? mem[b + 8'h01] : 8'h00), mem[b]}, "read data");
    ptr = b + 8'h01 + {7'h00, two};
  endtask

  task automatic wait_st(input pstate_t s, input logic a, input logic f);
    int n;
    n = 0;
    // long enough to wait out the whole init window
    while (power_state !== s && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    chk({30'h0, power_state}, {30'h0, s}, "power state");
    chk({30'h0, als_run, flicker_run}, {30'h0, a, f}, "run flags");
    chk({31'h0, i2c_awake}, 32'h0, "target awake after frame");
  endtask

  // overall time limit, well above the expected length of the run
  initial begin
    #6000000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    logic [7:0] en_tab [6];
    pstate_t    st_tab [6];
    logic [1:0] rn_tab [6];
    r1 = $urandom(82);
    en_tab = '{8'h01, 8'h03, 8'h43, 8'h41, 8'h01, 8'h00};
    st_tab = '{PS_IDLE, PS_ACTIVE, PS_ACTIVE, PS_ACTIVE, PS_IDLE, PS_SLEEP};
    rn_tab = '{2'b00, 2'b10, 2'b11, 2'b01, 2'b00, 2'b00};
    fail_count = 0;
    check_count = 0;
    foreach (mem[i]) mem[i] = 8'h00;
    ptr = 8'h00;
    {psel, penable, pwrite, irq_event} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(REG_ENABLE, 1'b0, 16'h0001, 1'b1);
    wait_st(PS_SLEEP, 1'b0, 1'b0);
    wr(8'h8c, 1'b0, 16'($urandom() & 32'hff), 1'b0);
    wait_st(PS_SLEEP, 1'b0, 1'b0);
    chk({31'h0, osc_run}, 32'h0, "oscillator after sleep access");
    wr(8'h8a, 1'b1, 16'($urandom()), 1'b0);
    rd(8'h8a, 1'b0, 1'b1);
    rd(8'h00, 1'b1, 1'b0);
    wr(PAIR_LO0, 1'b1, 16'($urandom()), 1'b0);
    rd(PAIR_LO0, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(REG_ENABLE, 1'b0, {8'h00, en_tab[i]}, 1'b0);
      wait_st(st_tab[i], rn_tab[i][1], rn_tab[i][0]);
    end
    wr(REG_CFG0, 1'b0, 16'h0004, 1'b0);
    wr(REG_ENABLE, 1'b0, 16'h0003, 1'b0);
    wait_st(PS_ACTIVE, 1'b1, 1'b0);
    irq_event <= 1'b1;
    @(posedge pclk);
    irq_event <= 1'b0;
    mem[REG_HOLD] = 8'h01;
    wait_st(PS_SLEEP, 1'b0, 1'b0);
    rd(REG_ENABLE, 1'b0, 1'b0);
    rd(REG_HOLD, 1'b0, 1'b0);
    wait_st(PS_SLEEP, 1'b0, 1'b0);
    wr(REG_CONTROL, 1'b0, 16'h0001, 1'b0);
    wait_st(PS_ACTIVE, 1'b1, 1'b0);
    rd(REG_HOLD, 1'b0, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, r1, e1);
    chk({31'h0, e1}, 32'h1, "unmapped apb error");
    chk(r1, 32'h0, "unmapped apb data");
    print_verdict();
  end
endmodule
